// *** hdl/clk_ctrl_pkg.sv ***
// Constants for the clock control, converter divider and reset request block
package clk_ctrl_pkg;

    localparam logic [7:0] PLL_LOW_ADDR   = 8'hF4;
    localparam logic [7:0] PLL_HIGH_ADDR  = 8'hF5;
    localparam logic [7:0] CONV_DIV_ADDR  = 8'hF6;
    localparam logic [7:0] RST_REQ_ADDR   = 8'hF7;

    localparam int PLL_HI_LSB      = 0;
    localparam int LOCK_BIT        = 4;
    localparam int STATUS_LSB      = 5;
    localparam int RST_REQ_BIT     = 0;

    localparam logic [7:0] PLL_LOW_RESET  = 8'h00;
    localparam logic [1:0] PLL_HIGH_RESET = 2'h0;
    localparam logic [6:0] CONV_DIV_RESET = 7'h03;
    localparam logic       RST_REQ_RESET  = 1'b0;

    localparam int MOD_RATIO = 64;

    localparam logic [4:0] SEL_OSC     = 5'h17;
    localparam logic [4:0] SEL_WR_HALF = 5'h19;
    localparam logic [4:0] SEL_T0_HALF = 5'h1B;
    localparam logic [4:0] SEL_T1_HALF = 5'h1D;
    localparam logic [4:0] SEL_MOD_HALF = 5'h1F;

    typedef enum logic [2:0] {
        MODE_RSVD0   = 3'b000,
        MODE_RSVD1   = 3'b001,
        MODE_RSVD2   = 3'b010,
        MODE_EXT     = 3'b011,
        MODE_PLL_HF  = 3'b100,
        MODE_PLL_LF  = 3'b101,
        MODE_INT_HF  = 3'b110,
        MODE_INT_LF  = 3'b111
    } clock_mode_t;

endpackage : clk_ctrl_pkg

// *** hdl/event_halver.sv ***
// Toggle stage that halves an event stream with a 50% duty cycle
`timescale 1ns/1ns
module event_halver (
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic event_in,
    output logic      half_out
);
    logic half_r;
    logic half_nxt;

    always_comb begin
        half_nxt = half_r ^ event_in;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            half_r <= 1'b0;
        end else begin
            half_r <= half_nxt;
        end
    end

    assign half_out = half_r;
endmodule : event_halver

// *** hdl/tick_divider.sv ***
// Reloading down counter that pulses once every value plus one cycles
`timescale 1ns/1ns
module tick_divider #(
    parameter int WIDTH = 7
) (
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire logic             step_in,
    input  wire logic [WIDTH-1:0] ratio_in,
    output logic                  tick_out
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             tick_r;
    logic             tick_nxt;

    always_comb begin
        count_nxt = count_r;
        tick_nxt  = 1'b0;
        if (step_in) begin
            // Ratio changes take effect at the next reload
            if (count_r == '0) begin
                count_nxt = ratio_in;
                tick_nxt  = 1'b1;
            end else begin
                count_nxt = count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r <= '0;
            tick_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            tick_r  <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule : tick_divider

// *** hdl/clk_ctrl.sv ***
// Clock output select, PLL multiplier, lock status, converter clock, reset req
`timescale 1ns/1ns
module clk_ctrl (
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic [7:0]      rdata_out,
    input  wire logic [2:0] clock_mode_in,
    input  wire logic [4:0] clkout_sel_in,
    input  wire logic       mem_wr_strobe_in,
    input  wire logic       t0_ovf_in,
    input  wire logic       t1_ovf_in,
    input  wire logic       osc_level_in,
    input  wire logic       pll_locked_in,
    output logic            clkout_out,
    output logic [9:0]      pll_multiplier_out,
    output logic            lock_detect_en_out,
    output logic            conv_clk_tick_out,
    output logic            mod_clk_tick_out,
    output logic            sys_reset_req_out
);
    logic [7:0] pll_low_r;
    logic [7:0] pll_low_nxt;
    logic [1:0] pll_high_r;
    logic [1:0] pll_high_nxt;
    logic       lock_en_r;
    logic       lock_en_nxt;
    logic [6:0] conv_div_r;
    logic [6:0] conv_div_nxt;
    logic       rst_req_r;
    logic       rst_req_nxt;
    logic       sys_rst_r;
    logic       sys_rst_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] osc_sync_r;
    logic [2:0] lock_sync_r;
    logic       osc_r;
    logic       osc_nxt;
    logic       locked_r;
    logic       locked_nxt;
    logic [5:0] mod_cnt_r;
    logic [5:0] mod_cnt_nxt;
    logic       mod_tick_r;
    logic       mod_tick_nxt;
    logic       clkout_r;
    logic       clkout_nxt;
    logic       conv_tick;
    logic [3:0] half_src;
    logic [3:0] half_clk;

    function automatic logic is_pll_mode(input logic [2:0] mode);
        return (mode == clk_ctrl_pkg::MODE_PLL_HF) ||
               (mode == clk_ctrl_pkg::MODE_PLL_LF);
    endfunction : is_pll_mode

    // Register writes
    always_comb begin
        pll_low_nxt  = pll_low_r;
        pll_high_nxt = pll_high_r;
        lock_en_nxt  = lock_en_r;
        conv_div_nxt = conv_div_r;
        rst_req_nxt  = rst_req_r;
        if (wr_in) begin
            case (addr_in)
                clk_ctrl_pkg::PLL_LOW_ADDR: begin
                    pll_low_nxt = wdata_in;
                end
                clk_ctrl_pkg::PLL_HIGH_ADDR: begin
                    pll_high_nxt = wdata_in[clk_ctrl_pkg::PLL_HI_LSB +: 2];
                    // Write of zero leaves detection as it is
                    if (wdata_in[clk_ctrl_pkg::LOCK_BIT]) begin
                        lock_en_nxt = 1'b1;
                    end
                end
                clk_ctrl_pkg::CONV_DIV_ADDR: begin
                    conv_div_nxt = wdata_in[6:0];
                end
                clk_ctrl_pkg::RST_REQ_ADDR: begin
                    rst_req_nxt = wdata_in[clk_ctrl_pkg::RST_REQ_BIT];
                end
                default: begin
                end
            endcase
        end
        // Fires once on the stored bit falling, never on a held one
        sys_rst_nxt = rst_req_r & ~rst_req_nxt;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pll_low_r  <= clk_ctrl_pkg::PLL_LOW_RESET;
            pll_high_r <= clk_ctrl_pkg::PLL_HIGH_RESET;
            lock_en_r  <= 1'b0;
            conv_div_r <= clk_ctrl_pkg::CONV_DIV_RESET;
            rst_req_r  <= clk_ctrl_pkg::RST_REQ_RESET;
            sys_rst_r  <= 1'b0;
        end else begin
            pll_low_r  <= pll_low_nxt;
            pll_high_r <= pll_high_nxt;
            lock_en_r  <= lock_en_nxt;
            conv_div_r <= conv_div_nxt;
            rst_req_r  <= rst_req_nxt;
            sys_rst_r  <= sys_rst_nxt;
        end
    end

    // Pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        osc_nxt = osc_r;
        if (osc_sync_r[1] == osc_sync_r[2]) begin
            osc_nxt = osc_sync_r[2];
        end
        locked_nxt = locked_r;
        if (lock_sync_r[1] == lock_sync_r[2]) begin
            locked_nxt = lock_sync_r[2];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_sync_r  <= 3'h0;
            lock_sync_r <= 3'h0;
            osc_r       <= 1'b0;
            locked_r    <= 1'b0;
        end else begin
            osc_sync_r  <= {osc_sync_r[1:0], osc_level_in};
            lock_sync_r <= {lock_sync_r[1:0], pll_locked_in};
            osc_r       <= osc_nxt;
            locked_r    <= locked_nxt;
        end
    end

    // Converter clock: counts the system clock, itself already divided
    // down from the oscillator ahead of this block
    tick_divider #(
        .WIDTH (7)
    ) u_conv_div (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .step_in  (1'b1),
        .ratio_in (conv_div_r),
        .tick_out (conv_tick)
    );

    // Modulator clock is the converter clock over a fixed ratio
    always_comb begin
        mod_cnt_nxt  = mod_cnt_r;
        mod_tick_nxt = 1'b0;
        if (conv_tick) begin
            if (mod_cnt_r == 6'(clk_ctrl_pkg::MOD_RATIO - 1)) begin
                mod_cnt_nxt  = 6'h0;
                mod_tick_nxt = 1'b1;
            end else begin
                mod_cnt_nxt = mod_cnt_r + 6'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mod_cnt_r  <= 6'h0;
            mod_tick_r <= 1'b0;
        end else begin
            mod_cnt_r  <= mod_cnt_nxt;
            mod_tick_r <= mod_tick_nxt;
        end
    end

    assign half_src = {mod_tick_r, t1_ovf_in, t0_ovf_in, mem_wr_strobe_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_half
            event_halver u_half (
                .mclk_in  (mclk_in),
                .rstn_in  (rstn_in),
                .event_in (half_src[gi]),
                .half_out (half_clk[gi])
            );
        end
    endgenerate

    // Lower select codes belong to other logic and leave the pin low here
    always_comb begin
        case (clkout_sel_in)
            clk_ctrl_pkg::SEL_OSC:      clkout_nxt = osc_r;
            clk_ctrl_pkg::SEL_WR_HALF:  clkout_nxt = half_clk[0];
            clk_ctrl_pkg::SEL_T0_HALF:  clkout_nxt = half_clk[1];
            clk_ctrl_pkg::SEL_T1_HALF:  clkout_nxt = half_clk[2];
            clk_ctrl_pkg::SEL_MOD_HALF: clkout_nxt = half_clk[3];
            default:                    clkout_nxt = 1'b0;
        endcase
    end

    // Register reads, data valid in the following cycle only
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd_in) begin
            case (addr_in)
                clk_ctrl_pkg::PLL_LOW_ADDR: begin
                    rdata_nxt = pll_low_r;
                end
                clk_ctrl_pkg::PLL_HIGH_ADDR: begin
                    rdata_nxt[clk_ctrl_pkg::STATUS_LSB +: 3] =
                        clock_mode_in;
                    // Lock only counts when the PLL is the running clock
                    rdata_nxt[clk_ctrl_pkg::LOCK_BIT] = lock_en_r &
                        locked_r & is_pll_mode(clock_mode_in);
                    rdata_nxt[clk_ctrl_pkg::PLL_HI_LSB +: 2] = pll_high_r;
                end
                clk_ctrl_pkg::CONV_DIV_ADDR: begin
                    rdata_nxt = {1'b0, conv_div_r};
                end
                clk_ctrl_pkg::RST_REQ_ADDR: begin
                    rdata_nxt = {7'h00, rst_req_r};
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_r  <= 8'h00;
            clkout_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            clkout_r <= clkout_nxt;
        end
    end

    assign rdata_out          = rdata_r;
    assign clkout_out         = clkout_r;
    assign pll_multiplier_out = {pll_high_r, pll_low_r};
    assign lock_detect_en_out = lock_en_r;
    assign conv_clk_tick_out  = conv_tick;
    assign mod_clk_tick_out   = mod_tick_r;
    assign sys_reset_req_out  = sys_rst_r;
endmodule : clk_ctrl

// *** verif/clk_ctrl_properties.sv ***
// Port-level checker for the clock control block
`timescale 1ns/1ns
module clk_ctrl_properties (
    input wire logic       mclk_in,
    input wire logic       rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [2:0] clock_mode_in,
    input wire logic [4:0] clkout_sel_in,
    input wire logic       t0_ovf_in,
    input wire logic       clkout_out,
    input wire logic [9:0] pll_multiplier_out,
    input wire logic       lock_detect_en_out,
    input wire logic       conv_clk_tick_out,
    input wire logic       sys_reset_req_out
);
    wire logic rd5 = rd_in && addr_in == clk_ctrl_pkg::PLL_HIGH_ADDR;
    wire logic wr5 = wr_in && addr_in == clk_ctrl_pkg::PLL_HIGH_ADDR;
    wire logic wr4 = wr_in && addr_in == clk_ctrl_pkg::PLL_LOW_ADDR;
    wire logic w7z = wr_in && addr_in == clk_ctrl_pkg::RST_REQ_ADDR
                     && !wdata_in[0];
    wire logic t0s = clkout_sel_in == clk_ctrl_pkg::SEL_T0_HALF;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    property p_mult;
        wr4 |=> pll_multiplier_out[7:0] == $past(wdata_in);
    endproperty
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_mode_readback: assert property (rd5 |=>
        rdata_out[7:5] == $past(clock_mode_in))
        else $error("status field differs from clock mode");
    a_lock_gate: assert property (rd5 && !(lock_detect_en_out
        && clock_mode_in[2:1] == 2'b10) |=> !rdata_out[4])
        else $error("lock bit set without detect and pll mode");
    a_lock_sticky: assert property (lock_detect_en_out |=>
        lock_detect_en_out)
        else $error("lock detect enable dropped");
    a_lock_enable: assert property (wr5 && wdata_in[4] |->
        ##[1:2] lock_detect_en_out)
        else $error("lock detect not enabled by write");
    a_mult_low: assert property (p_mult)
        else $error("multiplier low byte not updated");
    a_mult_high: assert property (wr5 |=>
        pll_multiplier_out[9:8] == $past(wdata_in[1:0]))
        else $error("multiplier high bits not updated");
    a_reset_pulse: assert property (sys_reset_req_out |=>
        !sys_reset_req_out)
        else $error("reset request longer than one cycle");
    a_reset_cause: assert property ($rose(sys_reset_req_out) |->
        $past(w7z) || $past(w7z, 2))
        else $error("reset request without clearing write");
    a_half_toggle: assert property (t0s && $past(t0s)
        && $past(t0s, 2) |-> (clkout_out != $past(clkout_out))
        == $past(t0_ovf_in, 2))
        else $error("clock output toggle not tied to event");
    a_other_zero: assert property ((clkout_sel_in == 5'h00)[*3]
        |-> !clkout_out)
        else $error("clock output active for unused code");
    cover property (sys_reset_req_out);
    cover property (rd5 ##1 rdata_out[4]);
    cover property (conv_clk_tick_out);
endmodule : clk_ctrl_properties

bind clk_ctrl clk_ctrl_properties chk (.mclk_in, .rstn_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .clock_mode_in, .clkout_sel_in,
    .t0_ovf_in, .clkout_out, .pll_multiplier_out, .lock_detect_en_out,
    .conv_clk_tick_out, .sys_reset_req_out);

// *** verif/tb.sv ***
// Self-checking testbench for the clock control block
`timescale 1ns/1ns
module tb;
    logic       mclk_in, rstn_in, wr_in, rd_in, osc_level_in, pll_locked_in;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [2:0] clock_mode_in, ev;
    logic [4:0] clkout_sel_in;
    logic [9:0] pll_multiplier_out;
    logic       clkout_out, lock_detect_en_out, conv_clk_tick_out;
    logic       mod_clk_tick_out, sys_reset_req_out, b;
    int         n_mismatch, tests_run, n_rst, n;
    logic [4:0] sel_tab [3] = '{clk_ctrl_pkg::SEL_WR_HALF,
        clk_ctrl_pkg::SEL_T0_HALF, clk_ctrl_pkg::SEL_T1_HALF};

    clk_ctrl dut (.mclk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .clock_mode_in, .clkout_sel_in, .mem_wr_strobe_in(ev[0]),
        .t0_ovf_in(ev[1]), .t1_ovf_in(ev[2]), .osc_level_in, .pll_locked_in,
        .clkout_out, .pll_multiplier_out, .lock_detect_en_out,
        .conv_clk_tick_out, .mod_clk_tick_out, .sys_reset_req_out);

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        if (sys_reset_req_out === 1'b1) n_rst++;
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in    <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in   <= 1'b0;
        @(negedge mclk_in);
        chk(rdata_out, exp);
    endtask : rd_reg
    task automatic idle(input int c);
        repeat (c) @(negedge mclk_in);
    endtask : idle
    task automatic pulse(input int i);
        @(posedge mclk_in);
        ev[i] <= 1'b1;
        @(posedge mclk_in);
        ev[i] <= 1'b0;
    endtask : pulse
    // Bounded so a dead divider ends the run instead of hanging it
    task automatic gap(input bit m, output int c);
        c = 0;
        do begin
            @(negedge mclk_in);
            c++;
            if (c > 1000) begin
                $display("unexpected at %0t: divider tick missing", $time);
                n_mismatch++;
                report_and_stop();
            end
        end while ((m ? mod_clk_tick_out : conv_clk_tick_out) !== 1'b1);
    endtask : gap

    initial begin
        rstn_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        ev = 3'h0;
        osc_level_in = 1'b0;
        pll_locked_in = 1'b0;
        clock_mode_in = 3'b011;
        clkout_sel_in = 5'h00;
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        rd_reg(8'hF4, 8'h00);
        rd_reg(8'hF5, 8'h60);
        rd_reg(8'hF6, 8'h03);
        rd_reg(8'hF7, 8'h00);
        rd_reg(8'hF8, 8'h00);
        wr_reg(8'hF4, 8'hA5);
        wr_reg(8'hF5, 8'hEF);
        idle(2);
        chk(pll_multiplier_out, 10'h3A5);
        @(posedge mclk_in);
        clock_mode_in <= 3'b100;
        pll_locked_in <= 1'b1;
        idle(8);
        rd_reg(8'hF5, 8'h83);
        wr_reg(8'hF5, 8'h13);
        // Short settling only: the block does not enforce the software wait
        idle(2);
        chk(lock_detect_en_out, 1'b1);
        rd_reg(8'hF5, 8'h93);
        @(posedge mclk_in);
        clock_mode_in <= 3'b101;
        rd_reg(8'hF5, 8'hB3);
        @(posedge mclk_in);
        pll_locked_in <= 1'b0;
        idle(8);
        rd_reg(8'hF5, 8'hA3);
        @(posedge mclk_in);
        clock_mode_in <= 3'b110;
        pll_locked_in <= 1'b1;
        idle(8);
        rd_reg(8'hF5, 8'hC3);
        wr_reg(8'hF6, 8'hFF);
        rd_reg(8'hF6, 8'h7F);
        wr_reg(8'hF6, 8'h02);
        repeat (3) gap(1'b0, n);
        chk(10'(n), 10'd3);
        repeat (2) gap(1'b1, n);
        chk(10'(n), 10'd192);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_in);
            clkout_sel_in <= sel_tab[i];
            idle(4);
            b = clkout_out;
            pulse(i);
            idle(4);
            chk(clkout_out, !b);
            pulse(i);
            idle(4);
            chk(clkout_out, b);
        end
        @(posedge mclk_in);
        clkout_sel_in <= clk_ctrl_pkg::SEL_MOD_HALF;
        idle(4);
        b = clkout_out;
        gap(1'b1, n);
        idle(4);
        chk(clkout_out, !b);
        @(posedge mclk_in);
        clkout_sel_in <= clk_ctrl_pkg::SEL_OSC;
        osc_level_in <= 1'b1;
        idle(8);
        chk(clkout_out, 1'b1);
        @(posedge mclk_in);
        osc_level_in <= 1'b0;
        idle(8);
        chk(clkout_out, 1'b0);
        wr_reg(8'hF7, 8'h00);
        wr_reg(8'hF7, 8'h01);
        wr_reg(8'hF7, 8'h01);
        idle(4);
        chk(10'(n_rst), 10'd0);
        rd_reg(8'hF7, 8'h01);
        wr_reg(8'hF7, 8'h00);
        idle(4);
        chk(10'(n_rst), 10'd1);
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        idle(2);
        @(posedge mclk_in);
        rstn_in <= 1'b1;
        rd_reg(8'hF6, 8'h03);
        chk(lock_detect_en_out, 1'b0);
        chk(pll_multiplier_out, 10'h000);
        report_and_stop();
    end
endmodule : tb
